/* File: hw/ats_pkg.sv */
/*
 * Package for the trigger source select block: register map, field
 * layout, trigger codes and the carrier struct shared with the top.
 * Assumes a single AHB-Lite slave with 32-bit data.
 */
package ats_pkg;

    // Register map (byte address within the block)
    localparam logic [11:0] ATS_OFS_SELECT = 12'h014;
    localparam logic [31:0] ATS_SELECT_RST = 32'h0000_0000;
    localparam int          ATS_NUM_SEQ    = 4;
    localparam int          ATS_FLD_W      = 4;
    localparam int          ATS_USED_W     = ATS_NUM_SEQ * ATS_FLD_W;

    // AHB-Lite encodings
    localparam logic [1:0]  ATS_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]  ATS_HTRANS_SEQ    = 2'h3;
    localparam logic [2:0]  ATS_HSIZE_WORD    = 3'h2;
    localparam logic        ATS_HRESP_OKAY    = 1'h0;

    // Trigger source codes
    typedef enum logic [3:0] {
        ATS_SRC_PROC   = 4'h0,
        ATS_SRC_COMP0  = 4'h1,
        ATS_SRC_EXT    = 4'h4,
        ATS_SRC_TIMER  = 4'h5,
        ATS_SRC_PWM0   = 4'h6,
        ATS_SRC_PWM1   = 4'h7,
        ATS_SRC_PWM2   = 4'h8,
        ATS_SRC_ALWAYS = 4'hF
    } ats_src_t;

    // Event sources, one bit each; the pin arrives on its own port
    typedef struct packed {
        logic comp0;
        logic timer;
        logic pwm0;
        logic pwm1;
        logic pwm2;
    } ats_events_t;

endpackage : ats_pkg

/* File: hw/ats_trigger_select.sv */
/*
 * Trigger source select: one 4-bit code per sample sequencer picks which
 * event becomes that sequencer's start-of-sampling request.
 * Assumes event inputs are one-cycle pulses in ref_clk domain, except the
 * external pin which is asynchronous, and one AHB-Lite master.
 */
`timescale 1ns/1ps

// Functional notes
// - Sequencer 2 field bits 11:8, reset zero
// - Sequencer 1 field bits 7:4, reset zero
// - Sequencer 0 field bits 3:0, reset zero
// - Software, comparator, pin and continuous source codes
// - Code 5 timer; timer enable kept outside
// - Code 6 selects PWM generator 0 trigger
// - Code 7 selects PWM generator 1 trigger
// - Code 8 selects PWM generator 2 trigger
// - Sequencer 3 field bits 15:12, same encoding
module ats_trigger_select #(
    parameter int NUM_SEQ = ats_pkg::ATS_NUM_SEQ
) (
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    // Trigger events
    input  wire logic [NUM_SEQ-1:0]    procRequest,
    input  wire ats_pkg::ats_events_t  events,
    input  wire logic                  external_trigger_pin,
    // Start-of-sampling requests
    output logic      [NUM_SEQ-1:0]    sampleStart
);

    localparam int FW = ats_pkg::ATS_FLD_W;

    // Decode a code against the event set; unknown codes give nothing
    function automatic logic pickEvent(input logic [3:0] code, input logic proc,
                                       input ats_pkg::ats_events_t ev,
                                       input logic pin);
        logic hit;
        hit = 1'b0;
        case (code)
            ats_pkg::ATS_SRC_PROC:   hit = proc;
            ats_pkg::ATS_SRC_COMP0:  hit = ev.comp0;
            ats_pkg::ATS_SRC_EXT:    hit = pin;
            ats_pkg::ATS_SRC_TIMER:  hit = ev.timer;
            ats_pkg::ATS_SRC_PWM0:   hit = ev.pwm0;
            ats_pkg::ATS_SRC_PWM1:   hit = ev.pwm1;
            ats_pkg::ATS_SRC_PWM2:   hit = ev.pwm2;
            ats_pkg::ATS_SRC_ALWAYS: hit = 1'b1;
            default:                 hit = 1'b0;
        endcase
        return hit;
    endfunction : pickEvent

    // Pin synchroniser and rising edge
    logic pinMeta;
    logic pinSync;
    logic pinLast;
    logic pinEdge;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pinMeta <= 1'b0;
            pinSync <= 1'b0;
            pinLast <= 1'b0;
        end else begin
            pinMeta <= external_trigger_pin;
            pinSync <= pinMeta;
            pinLast <= pinSync;
        end
    end

    assign pinEdge = pinSync & ~pinLast;

    // Bus address phase capture
    logic        wrPend;
    logic        next_wrPend;
    logic        next_rdPend;
    logic        addrHit;
    logic        phaseValid;
    logic [31:0] selectReg;
    logic [31:0] next_selectReg;
    logic [31:0] next_hrdata;

    assign phaseValid = hsel & hready &
                        ((htrans == ats_pkg::ATS_HTRANS_NONSEQ) |
                         (htrans == ats_pkg::ATS_HTRANS_SEQ));
    assign addrHit    = (haddr[11:0] == ats_pkg::ATS_OFS_SELECT);

    always_comb begin
        next_wrPend    = phaseValid & hwrite & addrHit;
        next_rdPend    = phaseValid & ~hwrite;
        next_selectReg = selectReg;
        next_hrdata    = hrdata;
        // field write, upper bits stay zero
        if (wrPend) begin
            next_selectReg = {{(32-ats_pkg::ATS_USED_W){1'b0}},
                              hwdata[ats_pkg::ATS_USED_W-1:0]};
        end
        // Unmapped reads return zero, writes to them are dropped
        if (next_rdPend) begin
            next_hrdata = addrHit ? next_selectReg : 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wrPend    <= 1'b0;
            selectReg <= ats_pkg::ATS_SELECT_RST;
            hrdata    <= 32'h0000_0000;
        end else begin
            wrPend    <= next_wrPend;
            selectReg <= next_selectReg;
            hrdata    <= next_hrdata;
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            hreadyout <= 1'b1;
            hresp     <= ats_pkg::ATS_HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= ats_pkg::ATS_HRESP_OKAY;
        end
    end

    // Per-sequencer source select, registered for clean outputs
    logic [NUM_SEQ-1:0] next_sampleStart;

    genvar s;
    generate
        for (s = 0; s < NUM_SEQ; s++) begin : g_seq
            assign next_sampleStart[s] = pickEvent(selectReg[s*FW +: FW],
                                                   procRequest[s], events, pinEdge);
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sampleStart <= '0;
        end else begin
            sampleStart <= next_sampleStart;
        end
    end

    // Assertions
    property p_reserved_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[11:8] == 4'h2) |=> !sampleStart[2];
    endproperty
    a_reserved_quiet: assert property (p_reserved_quiet)
        else $error("reserved code raised a request");

    property p_always_on;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[3:0] == 4'hF) |=> sampleStart[0];
    endproperty
    a_always_on: assert property (p_always_on)
        else $error("continuous mode did not request");

    property p_pwm0_pass;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[7:4] == 4'h6) |=> (sampleStart[1] == $past(events.pwm0));
    endproperty
    a_pwm0_pass: assert property (p_pwm0_pass)
        else $error("pwm0 trigger not forwarded");

    property p_pwm1_pass;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[11:8] == 4'h7) |=> (sampleStart[2] == $past(events.pwm1));
    endproperty
    a_pwm1_pass: assert property (p_pwm1_pass)
        else $error("pwm1 trigger not forwarded");

    property p_pwm2_pass;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[3:0] == 4'h8) |=> (sampleStart[0] == $past(events.pwm2));
    endproperty
    a_pwm2_pass: assert property (p_pwm2_pass)
        else $error("pwm2 trigger not forwarded");

    property p_timer_pass;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[15:12] == 4'h5) |=> (sampleStart[3] == $past(events.timer));
    endproperty
    a_timer_pass: assert property (p_timer_pass)
        else $error("timer trigger not forwarded");

    property p_proc_only;
        @(posedge ref_clk) disable iff (!nrst)
        (selectReg[7:4] == 4'h0) |=> (sampleStart[1] == $past(procRequest[1]));
    endproperty
    a_proc_only: assert property (p_proc_only)
        else $error("unselected source leaked through");

    property p_write_lands;
        @(posedge ref_clk) disable iff (!nrst)
        wrPend |=> (selectReg[15:0] == $past(hwdata[15:0])) && (selectReg[31:16] == 16'h0000);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("select write not stored");

    property p_hold;
        @(posedge ref_clk) disable iff (!nrst)
        !wrPend |=> $stable(selectReg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("select changed without a write");

endmodule : ats_trigger_select

/* File: test/tb_top.sv */
/*
 * Testbench for ats_trigger_select: register access over AHB-Lite,
 * every trigger code against every event source.
 * Assumes zero-wait slave, hready fed back from hreadyout.
 */
`timescale 1ns/1ps
module tb_top;
    logic                ref_clk, nrst, hsel, hwrite, pin;
    logic [31:0]         haddr, hwdata, hrdata;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [3:0]          procRequest, sampleStart;
    logic                hreadyout, hresp;
    ats_pkg::ats_events_t events;
    int                  err_count = 0, n_tests = 0;
    logic [31:0]         rd;

    ats_trigger_select uut (.ref_clk(ref_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .procRequest(procRequest), .events(events), .external_trigger_pin(pin),
        .sampleStart(sampleStart));

    initial begin
        ref_clk = 0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    // Entered just after a rising edge; waits on hready, no fixed latency
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= ats_pkg::ATS_HTRANS_NONSEQ;
        hwrite <= w;
        hsize  <= ats_pkg::ATS_HSIZE_WORD;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk({31'h0, hresp}, {31'h0, ats_pkg::ATS_HRESP_OKAY}, "hresp");
    endtask : xfer

    // Pulse one source, count request cycles per sequencer over 8 edges
    task automatic pulse_src(input logic [15:0] sel, input int src);
        logic [3:0] code [7];
        int         cnt [4];
        int         e;
        code = '{ats_pkg::ATS_SRC_PROC, ats_pkg::ATS_SRC_COMP0, ats_pkg::ATS_SRC_EXT,
                 ats_pkg::ATS_SRC_TIMER, ats_pkg::ATS_SRC_PWM0, ats_pkg::ATS_SRC_PWM1,
                 ats_pkg::ATS_SRC_PWM2};
        cnt = '{0, 0, 0, 0};
        case (src)
            0: procRequest <= 4'hF;
            1: events.comp0 <= 1'b1;
            2: pin <= 1'b1;
            3: events.timer <= 1'b1;
            4: events.pwm0 <= 1'b1;
            5: events.pwm1 <= 1'b1;
            default: events.pwm2 <= 1'b1;
        endcase
        @(posedge ref_clk);
        procRequest <= 4'h0;
        events      <= '0;
        repeat (8) begin
            @(posedge ref_clk);
            for (int i = 0; i < 4; i++) if (sampleStart[i] !== 1'b0) cnt[i]++;
        end
        pin <= 1'b0;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            e = (sel[i*4+:4] === 4'hF) ? 8 : (sel[i*4+:4] === code[src]) ? 1 : 0;
            chk(32'(cnt[i]), 32'(e), "request count");
        end
    endtask : pulse_src

    task automatic t_regs;
        xfer(1'b0, 32'(ats_pkg::ATS_OFS_SELECT), 32'h0);
        chk(rd, ats_pkg::ATS_SELECT_RST, "reset value");
        xfer(1'b1, 32'(ats_pkg::ATS_OFS_SELECT), 32'hFFFF_A5C3);
        xfer(1'b0, 32'(ats_pkg::ATS_OFS_SELECT), 32'h0);
        chk(rd, 32'h0000_A5C3, "readback");
        // Unmapped place: write ignored, reads zero
        xfer(1'b1, 32'h0000_0018, 32'hFFFF_FFFF);
        xfer(1'b0, 32'h0000_0018, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        xfer(1'b0, 32'(ats_pkg::ATS_OFS_SELECT), 32'h0);
        chk(rd, 32'h0000_A5C3, "after unmapped write");
        $display("test regs done");
    endtask : t_regs

    task automatic t_sel(input logic [15:0] sel);
        xfer(1'b1, 32'(ats_pkg::ATS_OFS_SELECT), {16'h0, sel});
        repeat (2) @(posedge ref_clk);
        for (int s = 0; s < 7; s++) pulse_src(sel, s);
    endtask : t_sel

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : summarize

    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        summarize();
    end

    initial begin
        nrst = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0; hwdata = 0;
        procRequest = 0; events = '0; pin = 0;
        repeat (20) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        t_regs();
        for (int c = 0; c < 16; c++) t_sel({4{4'(c)}});
        $display("test codes done");
        // Distinct source per sequencer
        t_sel(16'hF861);
        t_sel(16'h4725);
        $display("test independent done");
        summarize();
    end
endmodule : tb_top
